// ---- bench/pbs_bus_checker.sv ----
`timescale 1ns/1ps
`default_nettype none

module pbs_bus_checker
  import pbs_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // bus pins
  input wire logic [AD_W-1:0] pb_ad_in,
  input wire logic [CBE_W-1:0] pb_cbe_n_in,
  input wire logic pb_ad_oe_out,
  input wire logic pb_cbe_oe_out,
  input wire logic pb_par_out,
  input wire logic pb_par_oe_out,
  input wire logic pb_frame_n_in,
  input wire logic pb_frame_n_out,
  input wire logic pb_frame_oe_out,
  input wire logic pb_irdy_n_in,
  input wire logic pb_irdy_n_out,
  input wire logic pb_irdy_oe_out,
  input wire logic pb_trdy_n_in,
  input wire logic pb_devsel_n_in,
  input wire logic pb_gnt_n_in,
  // user side
  input wire logic ireq_valid_in,
  input wire logic ireq_ready_out,
  input wire logic iabort_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  a_par_follow: assert property (
    $past(pb_ad_oe_out) |-> pb_par_oe_out && pb_par_out == ^$past({pb_ad_in, pb_cbe_n_in}))
    else $error("parity does not follow driven lines");
  a_par_release: assert property (
    !pb_ad_oe_out && !$past(pb_ad_oe_out) |-> !pb_par_oe_out)
    else $error("parity driven without lines one clock before");
  a_park_lines: assert property (
    !pb_gnt_n_in && pb_frame_n_in && pb_irdy_n_in && ireq_ready_out && !ireq_valid_in
    |=> pb_ad_oe_out && pb_cbe_oe_out)
    else $error("idle bus under grant not parked");
  a_frame_release: assert property (
    pb_frame_oe_out && $rose(pb_frame_n_out) |=> !pb_frame_oe_out)
    else $error("frame not released after one high clock");
  a_irdy_release: assert property (
    pb_irdy_oe_out && $rose(pb_irdy_n_out) |=> !pb_irdy_oe_out)
    else $error("initiator ready not released after one high clock");
  a_irdy_hold: assert property (
    pb_irdy_oe_out && !pb_irdy_n_out && pb_trdy_n_in && !pb_devsel_n_in
    |=> pb_irdy_oe_out && !pb_irdy_n_out)
    else $error("initiator ready dropped before completion");
  a_abort_bound: assert property (
    $fell(pb_frame_n_out) && pb_frame_oe_out ##1 pb_devsel_n_in [*5] |-> ##[0:2] iabort_out)
    else $error("no master abort without device select");
  a_addr_phase: assert property (
    $fell(pb_frame_n_out) && pb_frame_oe_out |-> pb_ad_oe_out && pb_cbe_oe_out)
    else $error("address phase lines not driven");
endmodule // pbs_bus_checker

bind pbs_bus pbs_bus_checker i_chk (
  .core_clk_in, .rst_in, .pb_ad_in, .pb_cbe_n_in, .pb_ad_oe_out, .pb_cbe_oe_out,
  .pb_par_out, .pb_par_oe_out, .pb_frame_n_in, .pb_frame_n_out, .pb_frame_oe_out,
  .pb_irdy_n_in, .pb_irdy_n_out, .pb_irdy_oe_out, .pb_trdy_n_in, .pb_devsel_n_in,
  .pb_gnt_n_in, .ireq_valid_in, .ireq_ready_out, .iabort_out
);

`default_nettype wire

// ---- bench/pbs_target_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module pbs_target_model
  import pbs_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  // wire levels
  input wire logic [AD_W-1:0] ad_in,
  input wire logic [CBE_W-1:0] cbe_n_in,
  input wire logic frame_n_in,
  input wire logic irdy_n_in,
  // behaviour knobs
  input wire logic [1:0] lat_in,
  input wire logic absent_in,
  input wire logic bad_par_in,
  // driven pins
  output logic [AD_W-1:0] ad_out,
  output logic ad_oe_out,
  output logic par_out,
  output logic par_oe_out,
  output logic trdy_n_out,
  output logic devsel_n_out,
  output logic sel_oe_out,
  output logic [AD_W-1:0] wr_word_out
);
  logic act_q;
  logic rd_q;
  logic frame_q;
  logic fin_q;
  logic [2:0] cnt_q;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      act_q <= 1'b0;
      fin_q <= 1'b0;
      frame_q <= 1'b1;
      ad_oe_out <= 1'b0;
      par_oe_out <= 1'b0;
      sel_oe_out <= 1'b0;
      trdy_n_out <= 1'b1;
      devsel_n_out <= 1'b1;
    end else begin
      frame_q <= frame_n_in;
      par_out <= ^{ad_in, cbe_n_in} ^ bad_par_in;
      par_oe_out <= ad_oe_out;
      fin_q <= frame_n_in & act_q & ~trdy_n_out & ~irdy_n_in;
      if (fin_q) begin
        sel_oe_out <= 1'b0;
      end
      if (!act_q && frame_q && !frame_n_in && !absent_in) begin
        act_q <= 1'b1;
        rd_q <= cbe_n_in == CMD_MEM_RD;
        ad_out <= ad_in;
        // reads get a turnaround cycle before data
        cnt_q <= {1'b0, lat_in} + {2'h0, cbe_n_in == CMD_MEM_RD};
        devsel_n_out <= 1'b0;
        sel_oe_out <= 1'b1;
      end else if (act_q && !trdy_n_out && !irdy_n_in) begin
        wr_word_out <= rd_q ? wr_word_out : ad_in;
        ad_out <= ad_out + ADDR_STEP;
        ad_oe_out <= 1'b0;
        trdy_n_out <= 1'b1;
        cnt_q <= {1'b0, lat_in};
        act_q <= ~frame_n_in;
        devsel_n_out <= frame_n_in;
      end else if (act_q && cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end else if (act_q) begin
        trdy_n_out <= 1'b0;
        ad_oe_out <= rd_q;
      end
    end
  end
endmodule // pbs_target_model

`default_nettype wire

// ---- bench/test_pbs_bus.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_pbs_bus;
  import pbs_pkg::*;
  typedef struct packed {
    logic write;
    logic [LEN_W-1:0] len;
    logic [1:0] lat;
    logic absent;
    logic abort;
    logic [AD_W-1:0] addr;
  } pbs_row_t;
  localparam pbs_row_t ROWS [5] = '{
    '{1'b1, LEN_ONE, 2'h0, 1'b0, 1'b0, 32'h0001_0000},
    '{1'b0, LEN_ONE, 2'h0, 1'b0, 1'b0, 32'h0001_0100},
    '{1'b1, LEN_TWO, 2'h2, 1'b0, 1'b0, 32'h0001_0200},
    '{1'b0, 5'h03, 2'h1, 1'b0, 1'b0, 32'h0001_0300},
    '{1'b0, LEN_ONE, 2'h0, 1'b1, 1'b1, 32'h0001_0400}
  };
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic pb_gnt_n_in = 1'b1;
  logic ireq_valid_in = 1'b0;
  pbs_ireq_t ireq_in = '0;
  logic wdat_valid_in = 1'b0;
  pbs_wdat_t wdat_in = '0;
  logic [1:0] lat = 2'h0;
  logic absent = 1'b0;
  logic bad = 1'b0;
  // bench acting as another initiator on the bus
  logic b_oe = 1'b0;
  logic b_frame_n = 1'b1;
  logic b_irdy_n = 1'b1;
  logic [AD_W-1:0] b_ad = '0;
  logic [CBE_W-1:0] b_cbe = '0;
  logic twr_v;
  logic [AD_W-1:0] pb_ad_in, pb_ad_out, rdat_out, t_ad, t_wr, rd_exp;
  logic [AD_W-1:0] ad_q = '0;
  logic [CBE_W-1:0] pb_cbe_n_in, pb_cbe_n_out;
  logic [CBE_W-1:0] cbe_q = '0;
  logic par_q = 1'b0;
  logic pb_ad_oe_out, pb_cbe_oe_out, pb_par_in, pb_par_out, pb_par_oe_out;
  logic pb_frame_n_in, pb_frame_n_out, pb_frame_oe_out, pb_irdy_n_in, pb_irdy_n_out;
  logic pb_irdy_oe_out, pb_trdy_n_in, pb_trdy_n_out, pb_trdy_oe_out, pb_devsel_n_in;
  logic pb_devsel_n_out, pb_devsel_oe_out, pb_req_n_out, ireq_ready_out, wdat_ready_out;
  logic rdat_valid_out, idone_out, iabort_out, perr_out;
  logic t_ad_oe, t_par, t_par_oe, t_trdy_n, t_devsel_n, t_sel_oe;
  pbs_twr_t tgt_wr_out;
  int failures = 0;
  int compares = 0;
  int rd_cnt = 0;
  int perr_cnt = 0;
  int cycles = 0;

  always #25 core_clk_in = ~core_clk_in;

  // released lines show the inverse of their last level, strobes are pulled up
  assign pb_ad_in = pb_ad_oe_out ? pb_ad_out : (b_oe ? b_ad : (t_ad_oe ? t_ad : ~ad_q));
  assign pb_cbe_n_in = pb_cbe_oe_out ? pb_cbe_n_out : (b_oe ? b_cbe : ~cbe_q);
  assign pb_par_in = pb_par_oe_out ? pb_par_out : (t_par_oe ? t_par : ~par_q);
  assign pb_frame_n_in = pb_frame_oe_out ? pb_frame_n_out : (b_oe ? b_frame_n : 1'b1);
  assign pb_irdy_n_in = pb_irdy_oe_out ? pb_irdy_n_out : (b_oe ? b_irdy_n : 1'b1);
  assign pb_trdy_n_in = pb_trdy_oe_out ? pb_trdy_n_out : (t_sel_oe ? t_trdy_n : 1'b1);
  assign pb_devsel_n_in = pb_devsel_oe_out ? pb_devsel_n_out : (t_sel_oe ? t_devsel_n : 1'b1);

  pbs_bus i_dut (
    .core_clk_in, .rst_in, .pb_ad_in, .pb_ad_out, .pb_ad_oe_out, .pb_cbe_n_in, .pb_cbe_n_out,
    .pb_cbe_oe_out, .pb_par_in, .pb_par_out, .pb_par_oe_out, .pb_frame_n_in, .pb_frame_n_out,
    .pb_frame_oe_out, .pb_irdy_n_in, .pb_irdy_n_out, .pb_irdy_oe_out, .pb_trdy_n_in,
    .pb_trdy_n_out, .pb_trdy_oe_out, .pb_devsel_n_in, .pb_devsel_n_out, .pb_devsel_oe_out,
    .pb_gnt_n_in, .pb_req_n_out, .ireq_valid_in, .ireq_in, .ireq_ready_out, .wdat_valid_in,
    .wdat_in, .wdat_ready_out, .rdat_valid_out, .rdat_out, .idone_out, .iabort_out,
    .tgt_base_in(20'hfffff), .tgt_wr_valid_out(twr_v), .tgt_wr_out(tgt_wr_out),
    .tgt_rd_addr_out(),
    .tgt_rd_data_in(32'h0000_0000), .perr_out
  );

  pbs_target_model i_tgt (
    .core_clk_in, .rst_in, .ad_in(pb_ad_in), .cbe_n_in(pb_cbe_n_in),
    .frame_n_in(pb_frame_n_in), .irdy_n_in(pb_irdy_n_in), .lat_in(lat), .absent_in(absent),
    .bad_par_in(bad), .ad_out(t_ad), .ad_oe_out(t_ad_oe), .par_out(t_par),
    .par_oe_out(t_par_oe), .trdy_n_out(t_trdy_n), .devsel_n_out(t_devsel_n),
    .sel_oe_out(t_sel_oe), .wr_word_out(t_wr)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(negedge core_clk_in) begin
    ad_q <= pb_ad_in;
    cbe_q <= pb_cbe_n_in;
    par_q <= pb_par_in;
    cycles++;
    if (perr_out === 1'b1) perr_cnt++;
    if (rdat_valid_out === 1'b1) begin
      check("rdat", rdat_out, rd_exp);
      rd_exp = rd_exp + ADDR_STEP;
      rd_cnt++;
    end
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic run(input pbs_row_t r);
    int i;
    lat = r.lat;
    absent = r.absent;
    for (i = 0; i < r.len; i++) begin
      if (r.write) begin
        @(negedge core_clk_in);
        wdat_valid_in = 1'b1;
        wdat_in = '{r.addr + 32'(i), 4'h0};
        do @(posedge core_clk_in); while (wdat_ready_out !== 1'b1);
        @(negedge core_clk_in);
        wdat_valid_in = 1'b0;
      end
    end
    rd_exp = r.addr;
    rd_cnt = 0;
    @(negedge core_clk_in);
    ireq_valid_in = 1'b1;
    ireq_in = '{r.addr, r.write ? CMD_MEM_WR : CMD_MEM_RD, 4'h0, r.len, r.write};
    do @(posedge core_clk_in); while (ireq_ready_out !== 1'b1);
    @(negedge core_clk_in);
    ireq_valid_in = 1'b0;
    for (i = 0; i < 60; i++) begin
      @(negedge core_clk_in);
      if (idone_out === 1'b1) break;
    end
    check("end", {30'h0, iabort_out, idone_out}, {30'h0, r.abort, 1'b1});
    repeat (3) @(negedge core_clk_in);
    check("reads", 32'(rd_cnt), (r.write || r.absent) ? 32'h0 : 32'(r.len));
    if (r.write) check("wr_word", t_wr, r.addr + 32'(r.len) - 32'h1);
  endtask

  task automatic reset_check();
    check("rst_outs", {27'h0, ireq_ready_out, wdat_ready_out, pb_req_n_out, pb_ad_oe_out,
      pb_frame_oe_out}, 32'h1c);
  endtask

  initial begin
    repeat (2) @(posedge core_clk_in);
    @(negedge core_clk_in);
    reset_check();
    rst_in = 1'b0;
    pb_gnt_n_in = 1'b0;
    repeat (4) @(negedge core_clk_in);
    check("park_ad", pb_ad_oe_out ? pb_ad_out : ~PARK_AD, PARK_AD);
    check("park_par", {31'h0, pb_par_oe_out}, 32'h1);
    foreach (ROWS[k]) run(ROWS[k]);
    check("perr_idle", 32'(perr_cnt), 32'h0);
    bad = 1'b1;
    run(ROWS[3]);
    check("perr_bad", 32'(perr_cnt != 0), 32'h1);
    bad = 1'b0;
    // single-word write into the target window from another initiator
    absent = 1'b1;
    pb_gnt_n_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
    b_oe = 1'b1;
    b_frame_n = 1'b0;
    b_ad = 32'hffff_f010;
    b_cbe = CMD_MEM_WR;
    @(negedge core_clk_in);
    check("tgt_sel", {30'h0, pb_trdy_n_in, pb_devsel_n_in}, 32'h0);
    b_frame_n = 1'b1;
    b_irdy_n = 1'b0;
    b_ad = 32'h5a5a_0001;
    b_cbe = 4'h0;
    @(negedge core_clk_in);
    b_irdy_n = 1'b1;
    check("tgt_valid", {31'h0, twr_v}, 32'h1);
    check("tgt_data", tgt_wr_out.data, 32'h5a5a_0001);
    check("tgt_addr", tgt_wr_out.addr, 32'hffff_f010);
    @(negedge core_clk_in);
    b_oe = 1'b0;
    pb_gnt_n_in = 1'b0;
    absent = 1'b0;
    rst_in = 1'b1;
    @(negedge core_clk_in);
    reset_check();
    rst_in = 1'b0;
    run(ROWS[0]);
    wrap_up();
  end
endmodule // test_pbs_bus

`default_nettype wire

// ---- hdl/pbs_bus.sv ----
`timescale 1ns/1ps
`default_nettype none

// How it works
// - address then data travel on shared lines
// - park address and command lines under grant
// - initiator puts command in address phase
// - initiator drives byte enables each data phase
// - even parity over data and command lines
// - parity follows its lines one clock later
// - parity released one clock after lines
// - parked parity valid one clock after lines
// - receivers compare sampled parity with computed
// - frame starts transfer, drops at last phase
// - drive high one clock, then release
// - initiator-ready marks valid write data
// - target-ready held until phase completes
// - abort when no device-select within five clocks
module pbs_bus
  import pbs_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // primary bus pins, synchronous to core_clk_in
  input wire logic [AD_W-1:0] pb_ad_in,
  output logic [AD_W-1:0] pb_ad_out,
  output logic pb_ad_oe_out,
  input wire logic [CBE_W-1:0] pb_cbe_n_in,
  output logic [CBE_W-1:0] pb_cbe_n_out,
  output logic pb_cbe_oe_out,
  input wire logic pb_par_in,
  output logic pb_par_out,
  output logic pb_par_oe_out,
  input wire logic pb_frame_n_in,
  output logic pb_frame_n_out,
  output logic pb_frame_oe_out,
  input wire logic pb_irdy_n_in,
  output logic pb_irdy_n_out,
  output logic pb_irdy_oe_out,
  input wire logic pb_trdy_n_in,
  output logic pb_trdy_n_out,
  output logic pb_trdy_oe_out,
  input wire logic pb_devsel_n_in,
  output logic pb_devsel_n_out,
  output logic pb_devsel_oe_out,
  input wire logic pb_gnt_n_in,
  output logic pb_req_n_out,
  // initiator requests
  input wire logic ireq_valid_in,
  input wire pbs_ireq_t ireq_in,
  output logic ireq_ready_out,
  // initiator write data
  input wire logic wdat_valid_in,
  input wire pbs_wdat_t wdat_in,
  output logic wdat_ready_out,
  // initiator results
  output logic rdat_valid_out,
  output logic [AD_W-1:0] rdat_out,
  output logic idone_out,
  output logic iabort_out,
  // target side
  input wire logic [AD_W-1:TGT_WIN_BITS] tgt_base_in,
  output logic tgt_wr_valid_out,
  output pbs_twr_t tgt_wr_out,
  output logic [AD_W-1:0] tgt_rd_addr_out,
  input wire logic [AD_W-1:0] tgt_rd_data_in,
  output logic perr_out
);

  typedef struct packed {
    pbs_ist_t ist;
    pbs_tst_t tst;
    logic [AD_W-1:0] ad;
    logic ad_oe;
    logic [CBE_W-1:0] cbe;
    logic cbe_oe;
    logic par;
    logic par_oe;
    logic frame_n;
    logic frame_oe;
    logic irdy_n;
    logic irdy_oe;
    logic trdy_n;
    logic trdy_oe;
    logic devsel_n;
    logic devsel_oe;
    logic req_n;
    pbs_ireq_t ireq;
    logic [LEN_W-1:0] left;
    logic dsel_seen;
    logic [2:0] dsel_cnt;
    logic ireq_ready;
    logic rdat_valid;
    logic [AD_W-1:0] rdat;
    logic idone;
    logic iabort;
    logic [AD_W-1:0] tgt_addr;
    logic tgt_write;
    logic twr_valid;
    pbs_twr_t twr;
    logic frame_prev;
    logic chk;
    logic chk_par;
    logic perr;
  } pbs_state_t;

  pbs_state_t st_q;
  pbs_state_t s;

  // write data buffer
  logic fifo_valid;
  pbs_wdat_t fifo_word;
  logic fifo_pop;
  logic wdat_ready;

  pbs_fifo #(
    .WIDTH($bits(pbs_wdat_t)),
    .DEPTH(WFIFO_DEPTH)
  ) u_wfifo (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .in_valid_in(wdat_valid_in),
    .in_data_in(wdat_in),
    .in_ready_out(wdat_ready),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_word),
    .out_ready_in(fifo_pop)
  );

  // sustained tristate: low while active, high one clock, then released
  function automatic logic [1:0] sts(input logic act, input logic out_q, input logic oe_q);
    sts = {~act, act | (oe_q & ~out_q)};
  endfunction

  logic gnt;
  logic bus_idle;
  logic xfer;
  logic addr_phase;
  logic tgt_hit;
  logic fr_a;
  logic ir_a;
  logic tr_a;
  logic ds_a;

  always_comb begin
    s = st_q;
    fifo_pop = 1'b0;
    gnt = ~pb_gnt_n_in;
    bus_idle = pb_frame_n_in & pb_irdy_n_in;
    xfer = ~pb_irdy_n_in & ~pb_trdy_n_in;
    // someone else began a transaction at this edge
    addr_phase = st_q.frame_prev & ~pb_frame_n_in & ~st_q.frame_oe;
    tgt_hit = (pb_ad_in[AD_W-1:TGT_WIN_BITS] == tgt_base_in)
      && ((pb_cbe_n_in == CMD_MEM_RD) || (pb_cbe_n_in == CMD_MEM_WR));
    fr_a = st_q.frame_oe & ~st_q.frame_n;
    ir_a = st_q.irdy_oe & ~st_q.irdy_n;
    tr_a = st_q.trdy_oe & ~st_q.trdy_n;
    ds_a = st_q.devsel_oe & ~st_q.devsel_n;
    s.ad_oe = 1'b0;
    s.cbe_oe = 1'b0;
    s.rdat_valid = 1'b0;
    s.idone = 1'b0;
    s.iabort = 1'b0;
    s.twr_valid = 1'b0;
    s.perr = 1'b0;
    s.frame_prev = pb_frame_n_in;

    // initiator
    case (st_q.ist)
      I_IDLE: begin
        if (ireq_valid_in && st_q.ireq_ready) begin
          s.ireq = ireq_in;
          s.left = (ireq_in.len == '0) ? LEN_ONE : ireq_in.len;
          s.ireq_ready = 1'b0;
          s.req_n = 1'b0;
          s.ist = I_REQ;
        end
      end
      I_REQ: begin
        if (gnt && bus_idle && st_q.tst == T_IDLE && (!st_q.ireq.write || fifo_valid)) begin
          s.ad = st_q.ireq.addr;
          s.cbe = st_q.ireq.cmd;
          s.ad_oe = 1'b1;
          s.cbe_oe = 1'b1;
          fr_a = 1'b1;
          s.req_n = 1'b1;
          s.dsel_cnt = '0;
          s.dsel_seen = 1'b0;
          s.ist = I_ADDR;
        end
      end
      I_ADDR: begin
        s.cbe_oe = 1'b1;
        s.dsel_cnt = 3'h1;
        ir_a = 1'b1;
        if (st_q.ireq.write) begin
          fifo_pop = 1'b1;
          s.ad = fifo_word.data;
          s.cbe = fifo_word.be_n;
          s.ad_oe = 1'b1;
        end else begin
          s.cbe = st_q.ireq.be_n;
        end
        if (st_q.left == LEN_ONE) begin
          fr_a = 1'b0;
        end
        s.ist = I_DATA;
      end
      I_DATA: begin
        s.ad_oe = st_q.ad_oe;
        s.cbe_oe = 1'b1;
        if (!pb_devsel_n_in) begin
          s.dsel_seen = 1'b1;
        end else if (!st_q.dsel_seen) begin
          s.dsel_cnt = st_q.dsel_cnt + 1'b1;
        end
        if (!st_q.dsel_seen && pb_devsel_n_in && st_q.dsel_cnt == DEVSEL_CLKS) begin
          fr_a = 1'b0;
          ir_a = 1'b0;
          s.ad_oe = 1'b0;
          s.cbe_oe = 1'b0;
          s.iabort = 1'b1;
          s.idone = 1'b1;
          s.ist = I_TURN;
        end else if (xfer) begin
          if (!st_q.ireq.write) begin
            s.rdat_valid = 1'b1;
            s.rdat = pb_ad_in;
          end
          s.left = st_q.left - 1'b1;
          if (st_q.left == LEN_ONE) begin
            ir_a = 1'b0;
            s.ad_oe = 1'b0;
            s.cbe_oe = 1'b0;
            s.idone = 1'b1;
            s.ist = I_TURN;
          end else begin
            if (st_q.ireq.write) begin
              // an empty buffer inserts wait states
              ir_a = fifo_valid;
              if (fifo_valid) begin
                fifo_pop = 1'b1;
                s.ad = fifo_word.data;
                s.cbe = fifo_word.be_n;
              end
            end else begin
              ir_a = 1'b1;
            end
            fr_a = !(st_q.left == LEN_TWO && ir_a);
          end
        end else if (!ir_a && fifo_valid) begin
          fifo_pop = 1'b1;
          s.ad = fifo_word.data;
          s.cbe = fifo_word.be_n;
          ir_a = 1'b1;
          fr_a = (st_q.left != LEN_ONE);
        end
        // otherwise initiator-ready stays asserted until the phase completes
      end
      I_TURN: begin
        s.ireq_ready = 1'b1;
        s.ist = I_IDLE;
      end
      default: begin
        s.ist = I_IDLE;
      end
    endcase

    // target
    case (st_q.tst)
      T_IDLE: begin
        if (addr_phase && tgt_hit) begin
          s.tgt_addr = {pb_ad_in[AD_W-1:2], 2'b00};
          s.tgt_write = (pb_cbe_n_in == CMD_MEM_WR);
          ds_a = 1'b1;
          tr_a = (pb_cbe_n_in == CMD_MEM_WR);
          s.tst = (pb_cbe_n_in == CMD_MEM_WR) ? T_DATA : T_WAIT;
        end
      end
      T_WAIT: begin
        s.ad = tgt_rd_data_in;
        s.ad_oe = 1'b1;
        tr_a = 1'b1;
        s.tst = T_DATA;
      end
      T_DATA: begin
        s.ad_oe = ~st_q.tgt_write;
        if (xfer) begin
          if (st_q.tgt_write) begin
            s.twr_valid = 1'b1;
            s.twr = '{addr: st_q.tgt_addr, data: pb_ad_in, be_n: pb_cbe_n_in};
          end
          s.tgt_addr = st_q.tgt_addr + ADDR_STEP;
          if (pb_frame_n_in) begin
            ds_a = 1'b0;
            tr_a = 1'b0;
            s.ad_oe = 1'b0;
            s.tst = T_END;
          end else if (!st_q.tgt_write) begin
            // next read word comes from the advanced address
            tr_a = 1'b0;
            s.tst = T_WAIT;
          end
        end else if (pb_frame_n_in && pb_irdy_n_in) begin
          ds_a = 1'b0;
          tr_a = 1'b0;
          s.ad_oe = 1'b0;
          s.tst = T_END;
        end
        // else target-ready stays asserted until the phase completes
      end
      T_END: begin
        s.tst = T_IDLE;
      end
      default: begin
        s.tst = T_IDLE;
      end
    endcase

    // bus parking
    if ((s.ist == I_IDLE || s.ist == I_REQ) && s.tst == T_IDLE && !s.ad_oe
        && gnt && bus_idle && !addr_phase) begin
      s.ad = PARK_AD;
      s.cbe = PARK_CBE;
      s.ad_oe = 1'b1;
      s.cbe_oe = 1'b1;
    end

    // parity covers the previous cycle's lines
    s.par = ^{st_q.ad, (st_q.cbe_oe ? st_q.cbe : pb_cbe_n_in)};
    s.par_oe = st_q.ad_oe;

    // parity check on received address and data
    if (st_q.chk && (pb_par_in != st_q.chk_par)) begin
      s.perr = 1'b1;
    end
    s.chk = 1'b0;
    if (addr_phase || (xfer && !st_q.ad_oe
        && (st_q.ist == I_DATA || st_q.tst == T_DATA))) begin
      s.chk = 1'b1;
      s.chk_par = ^{pb_ad_in, pb_cbe_n_in};
    end

    {s.frame_n, s.frame_oe} = sts(fr_a, st_q.frame_n, st_q.frame_oe);
    {s.irdy_n, s.irdy_oe} = sts(ir_a, st_q.irdy_n, st_q.irdy_oe);
    {s.trdy_n, s.trdy_oe} = sts(tr_a, st_q.trdy_n, st_q.trdy_oe);
    {s.devsel_n, s.devsel_oe} = sts(ds_a, st_q.devsel_n, st_q.devsel_oe);
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= '0;
      st_q.frame_n <= 1'b1;
      st_q.irdy_n <= 1'b1;
      st_q.trdy_n <= 1'b1;
      st_q.devsel_n <= 1'b1;
      st_q.req_n <= 1'b1;
      st_q.frame_prev <= 1'b1;
      st_q.ireq_ready <= 1'b1;
    end else begin
      st_q <= s;
    end
  end

  assign pb_ad_out = st_q.ad;
  assign pb_ad_oe_out = st_q.ad_oe;
  assign pb_cbe_n_out = st_q.cbe;
  assign pb_cbe_oe_out = st_q.cbe_oe;
  assign pb_par_out = st_q.par;
  assign pb_par_oe_out = st_q.par_oe;
  assign pb_frame_n_out = st_q.frame_n;
  assign pb_frame_oe_out = st_q.frame_oe;
  assign pb_irdy_n_out = st_q.irdy_n;
  assign pb_irdy_oe_out = st_q.irdy_oe;
  assign pb_trdy_n_out = st_q.trdy_n;
  assign pb_trdy_oe_out = st_q.trdy_oe;
  assign pb_devsel_n_out = st_q.devsel_n;
  assign pb_devsel_oe_out = st_q.devsel_oe;
  assign pb_req_n_out = st_q.req_n;
  assign ireq_ready_out = st_q.ireq_ready;
  assign wdat_ready_out = wdat_ready;
  assign rdat_valid_out = st_q.rdat_valid;
  assign rdat_out = st_q.rdat;
  assign idone_out = st_q.idone;
  assign iabort_out = st_q.iabort;
  assign tgt_wr_valid_out = st_q.twr_valid;
  assign tgt_wr_out = st_q.twr;
  assign tgt_rd_addr_out = st_q.tgt_addr;
  assign perr_out = st_q.perr;

endmodule // pbs_bus

`default_nettype wire

// ---- hdl/pbs_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

module pbs_fifo
  import pbs_pkg::*;
#(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // filling side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // draining side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);

  // depth must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
    logic ready;
  } pbs_fifo_st_t;

  pbs_fifo_st_t st_q;
  pbs_fifo_st_t st_d;
  logic push;
  logic pop;

  always_comb begin
    st_d = st_q;
    push = in_valid_in && st_q.ready;
    pop = out_ready_in && (st_q.cnt != '0);
    if (push) begin
      st_d.mem[st_q.wr] = in_data_in;
      st_d.wr = st_q.wr + 1'b1;
    end
    if (pop) begin
      st_d.rd = st_q.rd + 1'b1;
    end
    case ({push, pop})
      2'b10: st_d.cnt = st_q.cnt + 1'b1;
      2'b01: st_d.cnt = st_q.cnt - 1'b1;
      default: st_d.cnt = st_q.cnt;
    endcase
    st_d.ready = (st_d.cnt != FULL_CNT);
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= '0;
      st_q.ready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign in_ready_out = st_q.ready;
  assign out_valid_out = (st_q.cnt != '0);
  assign out_data_out = st_q.mem[st_q.rd];

endmodule // pbs_fifo

`default_nettype wire

// ---- hdl/pbs_pkg.sv ----
`default_nettype none

package pbs_pkg;

  // bus widths
  localparam int AD_W = 32;
  localparam int CBE_W = 4;
  localparam int LEN_W = 5;

  // write data buffer depth in words
  localparam int WFIFO_DEPTH = 32;

  // target claims a window of 2**TGT_WIN_BITS bytes
  localparam int TGT_WIN_BITS = 12;

  // clocks after frame assertion that device-select may take
  localparam logic [2:0] DEVSEL_CLKS = 3'h5;

  // bus commands decoded by the target
  localparam logic [CBE_W-1:0] CMD_MEM_RD = 4'h6;
  localparam logic [CBE_W-1:0] CMD_MEM_WR = 4'h7;

  // values driven while parking the idle bus
  localparam logic [AD_W-1:0] PARK_AD = 32'h0000_0000;
  localparam logic [CBE_W-1:0] PARK_CBE = 4'h0;

  localparam logic [AD_W-1:0] ADDR_STEP = 32'h0000_0004;
  localparam logic [LEN_W-1:0] LEN_ONE = 5'h01;
  localparam logic [LEN_W-1:0] LEN_TWO = 5'h02;

  // initiator request
  typedef struct packed {
    logic [AD_W-1:0] addr;
    logic [CBE_W-1:0] cmd;
    logic [CBE_W-1:0] be_n;
    logic [LEN_W-1:0] len;
    logic write;
  } pbs_ireq_t;

  // one buffered write word with its byte enables (active low)
  typedef struct packed {
    logic [AD_W-1:0] data;
    logic [CBE_W-1:0] be_n;
  } pbs_wdat_t;

  // one word written into the device as target
  typedef struct packed {
    logic [AD_W-1:0] addr;
    logic [AD_W-1:0] data;
    logic [CBE_W-1:0] be_n;
  } pbs_twr_t;

  typedef enum logic [2:0] {I_IDLE, I_REQ, I_ADDR, I_DATA, I_TURN} pbs_ist_t;
  typedef enum logic [1:0] {T_IDLE, T_WAIT, T_DATA, T_END} pbs_tst_t;

endpackage

`default_nettype wire
